/* File: core/iex_exec.sv */
// execute slice: add, and, call, clear, complement and watchdog-clear instructions
//
// Notes on behaviour
// - add-with-carry from memory: acc plus byte plus carry into acc, five flags
// - memory-destination adds write sum to memory, acc kept, same flags
// - plain memory add: acc plus byte without carry into acc, five flags
// - immediate add: acc plus literal into acc, same five flags
// - memory and: acc and byte into acc, only zero flag
// - immediate and: acc and literal into acc, only zero flag
// - memory-destination and writes acc and byte back to memory
// - call pushes pc plus one and loads target into pc in the same cycle
// - call takes two instruction cycles
// - byte clear writes zero to memory, flags untouched
// - bit clear zeroes only the selected bit, flags untouched
// - single watchdog clear resets counter, clears expired and powerdown flags
// - paired clears take effect only when first and second alternate
// - a repeated paired clear of same kind is ignored
// - complement inverts memory byte, writes back, updates zero flag
// - halt sets powerdown flag and clears expired flag
// - instructions writing low pc byte take two cycles
`timescale 1ns/1ps
`include "iex_cfg.svh"
module iex_exec
(
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire logic                  issue,
   input  wire iex_pkg::iex_instr_type instr,
   input  wire logic [`IEX_PC_W-1:0]  pc_in,
   input  wire logic                  halt,
   input  wire logic                  dog_timeout,
   output logic                       busy,
   output logic [7:0]                 working_register,
   output logic [4:0]                 flags,
   output logic                       watchdog_expired_flag,
   output logic                       powerdown_flag,
   output logic                       watchdog_counter_clr,
   output iex_pkg::iex_mem_wr_type    mem_wr,
   output iex_pkg::iex_push_type      stack_push,
   output logic                       pc_load,
   output logic [`IEX_PC_W-1:0]       pc_target
);
   import iex_pkg::*;

   // ************************************************************
   // state and next values
   // ************************************************************
   logic [7:0]           acc_q, acc_d;
   logic [4:0]           flg_q, flg_d;
   logic                 to_q, pdf_q;
   iex_kick_type         last_kick_q;
   logic                 stall_q;
   iex_mem_wr_type       mem_q, mem_d;
   iex_push_type         push_q, push_d;
   logic                 pcl_q, pcl_d;
   logic [`IEX_PC_W-1:0] tgt_q, tgt_d;
   logic                 clr_q;
   logic                 kick_ok;

   // ************************************************************
   // adder shared by all sum instructions
   // ************************************************************
   logic [7:0] addend;
   logic       cin;
   logic [4:0] lo_sum;
   logic [3:0] hi_sum;
   logic [7:0] sum;
   logic       c7, c6;
   logic       take;

   // the sequencer must not issue while busy; a stray issue is dropped
   assign take = issue && !stall_q;

   always_comb
   begin
      addend = (instr.op == IEX_SUM_IMM_OP) ? instr.literal : instr.mem_data;
      cin    = (instr.op == IEX_SUM_WITH_CARRY_OP ||
                instr.op == IEX_SUM_WITH_CARRY_TO_MEM_OP) ? flg_q[`IEX_FLG_C] : 1'b0;
      lo_sum = {1'b0, acc_q[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
      // split at bit 6 so the sign carry can be taken for overflow
      hi_sum = {1'b0, acc_q[6:4]} + {1'b0, addend[6:4]} + {3'h0, lo_sum[4]};
      c6     = hi_sum[3];
      c7     = (acc_q[7] & addend[7]) | (c6 & (acc_q[7] ^ addend[7]));
      sum    = {acc_q[7] ^ addend[7] ^ c6, hi_sum[2:0], lo_sum[3:0]};
   end

   // ************************************************************
   // instruction decode into next values
   // ************************************************************
   always_comb
   begin
      acc_d  = acc_q;
      flg_d  = flg_q;
      mem_d  = '0;
      push_d = '0;
      pcl_d  = 1'b0;
      tgt_d  = tgt_q;
      if (take)
      begin
         unique case (instr.op)
            IEX_SUM_WITH_CARRY_OP, IEX_SUM_OP, IEX_SUM_IMM_OP,
            IEX_SUM_WITH_CARRY_TO_MEM_OP, IEX_SUM_TO_MEM_OP:
            begin
               if (instr.op == IEX_SUM_WITH_CARRY_TO_MEM_OP || instr.op == IEX_SUM_TO_MEM_OP)
               begin
                  mem_d = '{we: 1'b1, data: sum};
               end
               else
               begin
                  acc_d = sum;
               end
               flg_d[`IEX_FLG_C]  = c7;
               flg_d[`IEX_FLG_AC] = lo_sum[4];
               flg_d[`IEX_FLG_Z]  = (sum == `IEX_BYTE_ZERO);
               flg_d[`IEX_FLG_OV] = c7 ^ c6;
               // sign of the true result: sum msb corrected by overflow
               flg_d[`IEX_FLG_SC] = sum[7] ^ (c7 ^ c6);
            end
            IEX_CONJ_OP, IEX_CONJ_IMM_OP:
            begin
               acc_d = acc_q & ((instr.op == IEX_CONJ_IMM_OP) ? instr.literal
                                                               : instr.mem_data);
               flg_d[`IEX_FLG_Z] = (acc_d == `IEX_BYTE_ZERO);
            end
            IEX_BITWISE_CONJ_TO_MEM_OP:
            begin
               mem_d = '{we: 1'b1, data: acc_q & instr.mem_data};
               flg_d[`IEX_FLG_Z] = ((acc_q & instr.mem_data) == `IEX_BYTE_ZERO);
            end
            IEX_CALL_OP:
            begin
               push_d = '{push: 1'b1, addr: pc_in + `IEX_PC_STEP};
               pcl_d  = 1'b1;
               tgt_d  = instr.target;
            end
            IEX_ZERO_MEM_OP:
            begin
               mem_d = '{we: 1'b1, data: `IEX_BYTE_ZERO};
            end
            IEX_ZERO_BIT_OP:
            begin
               mem_d.we   = 1'b1;
               mem_d.data = instr.mem_data & ~(8'h01 << instr.bit_sel);
            end
            IEX_INVERT_MEM_OP:
            begin
               mem_d = '{we: 1'b1, data: instr.mem_data ^ `IEX_BYTE_ONES};
               flg_d[`IEX_FLG_Z] = (instr.mem_data == `IEX_BYTE_ONES);
            end
            IEX_NOP, IEX_SINGLE_DOG_KICK_OP, IEX_PAIRED_DOG_KICK_FIRST_OP,
            IEX_PAIRED_DOG_KICK_SECOND_OP:
            begin
            end
         endcase
      end
   end

   // ************************************************************
   // working register and arithmetic flags
   // ************************************************************
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         acc_q <= `IEX_ACC_RST;
         flg_q <= `IEX_FLG_RST;
      end
      else
      begin
         acc_q <= acc_d;
         flg_q <= flg_d;
      end
   end

   // ************************************************************
   // memory, stack and program counter strobes (one-cycle pulses)
   // ************************************************************
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         mem_q  <= '0;
         push_q <= '0;
         pcl_q  <= 1'b0;
         tgt_q  <= '0;
      end
      else
      begin
         mem_q  <= mem_d;
         push_q <= push_d;
         pcl_q  <= pcl_d;
         tgt_q  <= tgt_d;
      end
   end

   // ************************************************************
   // two-cycle instructions insert one dummy cycle
   // ************************************************************
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         stall_q <= 1'b0;
      end
      else
      begin
         // call and any low pc byte write cost the dummy cycle
         stall_q <= take && (instr.op == IEX_CALL_OP || instr.low_pc_write);
      end
   end

   // ************************************************************
   // watchdog clear alternation and status flags
   // ************************************************************
   always_comb
   begin
      kick_ok = 1'b0;
      if (take)
      begin
         // paired kinds must alternate; a repeat of the last kind is ignored
         kick_ok = (instr.op == IEX_SINGLE_DOG_KICK_OP)
                || (instr.op == IEX_PAIRED_DOG_KICK_FIRST_OP
                    && last_kick_q != IEX_KICK_FIRST)
                || (instr.op == IEX_PAIRED_DOG_KICK_SECOND_OP
                    && last_kick_q != IEX_KICK_SECOND);
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         last_kick_q <= IEX_KICK_NONE;
      end
      else if (take && instr.op == IEX_PAIRED_DOG_KICK_FIRST_OP)
      begin
         last_kick_q <= IEX_KICK_FIRST;
      end
      else if (take && instr.op == IEX_PAIRED_DOG_KICK_SECOND_OP)
      begin
         last_kick_q <= IEX_KICK_SECOND;
      end
   end

   // a timeout in the same cycle as a clear wins, so an expiry is never lost
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         to_q  <= `IEX_TO_RST;
         pdf_q <= `IEX_PDF_RST;
         clr_q <= 1'b0;
      end
      else
      begin
         clr_q <= kick_ok || halt;
         if (dog_timeout)
         begin
            to_q <= 1'b1;
         end
         else if (kick_ok || halt)
         begin
            to_q <= 1'b0;
         end
         if (halt)
         begin
            pdf_q <= 1'b1;
         end
         else if (kick_ok)
         begin
            pdf_q <= 1'b0;
         end
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign busy                  = stall_q;
   assign working_register      = acc_q;
   assign flags                 = flg_q;
   assign watchdog_expired_flag = to_q;
   assign powerdown_flag        = pdf_q;
   assign watchdog_counter_clr  = clr_q;
   assign mem_wr                = mem_q;
   assign stack_push            = push_q;
   assign pc_load               = pcl_q;
   assign pc_target             = tgt_q;
endmodule : iex_exec

/* File: core/iex_cfg.svh */
// constants for the instruction execute slice: widths, flag positions, reset values
`ifndef IEX_CFG_SVH
`define IEX_CFG_SVH
`define IEX_PC_W        13
`define IEX_PC_STEP     13'h0001
`define IEX_ACC_RST     8'h00
`define IEX_BYTE_ZERO   8'h00
`define IEX_BYTE_ONES   8'hff
`define IEX_FLG_C       0
`define IEX_FLG_AC      1
`define IEX_FLG_Z       2
`define IEX_FLG_OV      3
`define IEX_FLG_SC      4
`define IEX_FLG_RST     5'h00
`define IEX_TO_RST      1'b0
`define IEX_PDF_RST     1'b0
`define IEX_LONG_CYCLES 2'h2
`endif

/* File: core/iex_pkg.sv */
// types for the instruction execute slice
`include "iex_cfg.svh"
package iex_pkg;
   typedef enum logic [3:0]
   {
      IEX_NOP,
      IEX_SUM_WITH_CARRY_OP,
      IEX_SUM_WITH_CARRY_TO_MEM_OP,
      IEX_SUM_OP,
      IEX_SUM_TO_MEM_OP,
      IEX_SUM_IMM_OP,
      IEX_CONJ_OP,
      IEX_CONJ_IMM_OP,
      IEX_BITWISE_CONJ_TO_MEM_OP,
      IEX_CALL_OP,
      IEX_ZERO_MEM_OP,
      IEX_ZERO_BIT_OP,
      IEX_SINGLE_DOG_KICK_OP,
      IEX_PAIRED_DOG_KICK_FIRST_OP,
      IEX_PAIRED_DOG_KICK_SECOND_OP,
      IEX_INVERT_MEM_OP
   } iex_op_type;

   // one instruction as issued by the sequencer
   typedef struct packed
   {
      iex_op_type               op;
      logic [7:0]               mem_data;
      logic [7:0]               literal;
      logic [2:0]               bit_sel;
      logic [`IEX_PC_W-1:0]     target;
      logic                     low_pc_write;
   } iex_instr_type;

   // data memory write-back
   typedef struct packed
   {
      logic       we;
      logic [7:0] data;
   } iex_mem_wr_type;

   // stack push request
   typedef struct packed
   {
      logic                 push;
      logic [`IEX_PC_W-1:0] addr;
   } iex_push_type;

   typedef enum logic [1:0]
   {
      IEX_KICK_NONE,
      IEX_KICK_FIRST,
      IEX_KICK_SECOND
   } iex_kick_type;
endpackage : iex_pkg

/* File: tb/iex_exec_assertions.sv */
// port-level checker for the instruction execute slice
`timescale 1ns/1ps
`include "iex_cfg.svh"
module iex_exec_assertions
(
   input wire logic                    mclk,
   input wire logic                    rst,
   input wire logic                    issue,
   input wire iex_pkg::iex_instr_type  instr,
   input wire logic [`IEX_PC_W-1:0]    pc_in,
   input wire logic                    halt,
   input wire logic                    dog_timeout,
   input wire logic                    busy,
   input wire logic [7:0]              working_register,
   input wire logic [4:0]              flags,
   input wire logic                    watchdog_expired_flag,
   input wire logic                    powerdown_flag,
   input wire logic                    watchdog_counter_clr,
   input wire iex_pkg::iex_mem_wr_type mem_wr,
   input wire iex_pkg::iex_push_type   stack_push,
   input wire logic                    pc_load
);
   import iex_pkg::*;
   // ****************
   // properties
   // ****************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic take;
   // an issue only counts when the slice is not in its dummy cycle
   assign take = issue && !busy;
   // a taken op of one kind, no halt or timeout beside it
   sequence op_s(iex_op_type k);
      take && instr.op == k && !halt && !dog_timeout;
   endsequence
   sum_acc_a: assert property (op_s(IEX_SUM_OP) |=>
      {flags[0], working_register} == 9'($past(working_register)) + 9'($past(instr.mem_data)))
      else $error("plain add result or carry wrong");
   sum_mem_a: assert property (op_s(IEX_SUM_TO_MEM_OP) |=> mem_wr.we
      && $stable(working_register)
      && {flags[0], mem_wr.data} == 9'($past(working_register)) + 9'($past(instr.mem_data)))
      else $error("memory add result or carry wrong");
   conj_zero_a: assert property (op_s(IEX_CONJ_OP) |=>
      flags[2] == (working_register == 8'h00) && (flags & 5'h1b) == ($past(flags) & 5'h1b))
      else $error("memory and touched a flag other than zero");
   call_push_a: assert property (op_s(IEX_CALL_OP) |=> stack_push.push && pc_load
      && stack_push.addr == $past(pc_in) + 13'h1)
      else $error("call push or load wrong");
   call_busy_a: assert property (take &&
      (instr.op == IEX_CALL_OP || instr.low_pc_write) |=> busy ##1 !busy)
      else $error("two-cycle op without exactly one dummy cycle");
   busy_drop_a: assert property (busy && issue |=> !mem_wr.we && !stack_push.push
      && $stable(working_register))
      else $error("issue during dummy cycle was executed");
   zero_mem_a: assert property (op_s(IEX_ZERO_MEM_OP) |=> mem_wr.we
      && mem_wr.data == 8'h00 && $stable(flags))
      else $error("byte clear wrong");
   invert_mem_a: assert property (op_s(IEX_INVERT_MEM_OP) |=>
      mem_wr.data == ~$past(instr.mem_data) && flags[2] == (mem_wr.data == 8'h00))
      else $error("complement wrong");
   kick_single_a: assert property (op_s(IEX_SINGLE_DOG_KICK_OP) |=> watchdog_counter_clr
      && !watchdog_expired_flag && !powerdown_flag)
      else $error("single kick did not clear");
   kick_repeat_a: assert property (op_s(IEX_PAIRED_DOG_KICK_FIRST_OP) ##1
      op_s(IEX_PAIRED_DOG_KICK_FIRST_OP) |=> !watchdog_counter_clr && $stable(powerdown_flag))
      else $error("repeated paired kick took effect");
   halt_flags_a: assert property (halt && !dog_timeout |=> powerdown_flag
      && !watchdog_expired_flag && watchdog_counter_clr)
      else $error("halt flags wrong");
endmodule : iex_exec_assertions
bind iex_exec iex_exec_assertions u_chk (.*);

/* File: tb/iex_mem_model.sv */
// one data memory byte behind the execute slice
`timescale 1ns/1ps
module iex_mem_model
(
   input  wire logic                    mclk,
   input  wire logic                    rst,
   input  wire iex_pkg::iex_mem_wr_type mem_wr,
   output logic [7:0]                   mem_data
);
   import iex_pkg::*;
   logic [7:0] mem_q;
   // ****************
   // storage
   // ****************
   // byte lands at the edge after the write pulse appears
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         mem_q <= 8'h00;
      else if (mem_wr.we)
         mem_q <= mem_wr.data;
   end
   // forward a write in flight so back-to-back ops read fresh data
   assign mem_data = mem_wr.we ? mem_wr.data : mem_q;
endmodule : iex_mem_model

/* File: tb/test_instr_exec_add_logic_call_wdt.sv */
// self-checking bench for the instruction execute slice
`timescale 1ns/1ps
`include "iex_cfg.svh"
module test_instr_exec_add_logic_call_wdt;
   import iex_pkg::*;
   logic mclk, rst, issue, halt, dog_timeout, busy, pc_load, watchdog_counter_clr;
   logic watchdog_expired_flag, powerdown_flag, e_to, e_pdf;
   logic [7:0] working_register, mem_data, e_acc, e_mem;
   logic [4:0] flags, e_flg;
   logic [`IEX_PC_W-1:0] pc_in, pc_target;
   iex_instr_type instr;
   iex_mem_wr_type mem_wr;
   iex_push_type stack_push;
   iex_op_type e_kick;
   int error_cnt, samples_checked, i;
   // ****************
   // harness
   // ****************
   iex_exec dut (.*);
   iex_mem_model u_mem (.mclk(mclk), .rst(rst), .mem_wr(mem_wr), .mem_data(mem_data));
   // 100 MHz clock
   always #5 mclk = ~mclk;
   // compare one value and count it
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   // expected {sc, ov, z, ac, c, sum}
   function automatic logic [12:0] add_f(input logic [7:0] a, b, input logic ci);
      logic [8:0] s;
      logic c6, ac;
      s = a + b + ci;
      c6 = ({1'b0, a[6:0]} + b[6:0] + ci) > 8'h7f;
      ac = ({1'b0, a[3:0]} + b[3:0] + ci) > 5'h0f;
      return {s[7] ^ s[8] ^ c6, s[8] ^ c6, s[7:0] == 8'h00, ac, s[8], s[7:0]};
   endfunction : add_f
   // issue one op, predict it, then check the answer one cycle on
   task automatic run(input iex_op_type op, input logic [7:0] lit, input logic [2:0] b,
                      input logic lpw);
      logic [12:0] p;
      logic e_clr;
      logic e_we;
      p = 13'($urandom);
      e_clr = (op == IEX_SINGLE_DOG_KICK_OP);
      e_we = op inside {IEX_SUM_WITH_CARRY_TO_MEM_OP, IEX_SUM_TO_MEM_OP, IEX_ZERO_MEM_OP,
                        IEX_ZERO_BIT_OP, IEX_INVERT_MEM_OP, IEX_BITWISE_CONJ_TO_MEM_OP};
      issue = 1'b1;
      pc_in = p;
      instr = '{op, mem_data, lit, b, ~p, lpw};
      case (op)
         IEX_SUM_WITH_CARRY_OP: {e_flg, e_acc} = add_f(e_acc, e_mem, e_flg[0]);
         IEX_SUM_WITH_CARRY_TO_MEM_OP: {e_flg, e_mem} = add_f(e_acc, e_mem, e_flg[0]);
         IEX_SUM_OP: {e_flg, e_acc} = add_f(e_acc, e_mem, 1'b0);
         IEX_SUM_TO_MEM_OP: {e_flg, e_mem} = add_f(e_acc, e_mem, 1'b0);
         IEX_SUM_IMM_OP: {e_flg, e_acc} = add_f(e_acc, lit, 1'b0);
         IEX_CONJ_OP: e_acc = e_acc & e_mem;
         IEX_CONJ_IMM_OP: e_acc = e_acc & lit;
         IEX_BITWISE_CONJ_TO_MEM_OP: e_mem = e_acc & e_mem;
         IEX_ZERO_MEM_OP: e_mem = 8'h00;
         IEX_ZERO_BIT_OP: e_mem[b] = 1'b0;
         IEX_INVERT_MEM_OP: e_mem = ~e_mem;
         default: ;
      endcase
      if (op inside {IEX_CONJ_OP, IEX_CONJ_IMM_OP})
         e_flg[2] = (e_acc == 8'h00);
      if (op inside {IEX_BITWISE_CONJ_TO_MEM_OP, IEX_INVERT_MEM_OP})
         e_flg[2] = (e_mem == 8'h00);
      // a paired kick only counts when it differs from the last paired kind
      if (op inside {IEX_PAIRED_DOG_KICK_FIRST_OP, IEX_PAIRED_DOG_KICK_SECOND_OP} && op != e_kick)
      begin
         e_kick = op;
         e_clr = 1'b1;
      end
      e_to = e_to & ~e_clr;
      e_pdf = e_pdf & ~e_clr;
      @(posedge mclk);
      #1;
      chk(working_register, e_acc);
      chk(flags, e_flg);
      chk(mem_wr.we, e_we);
      if (mem_wr.we === 1'b1)
         chk(mem_wr.data, e_mem);
      chk({watchdog_counter_clr, watchdog_expired_flag, powerdown_flag},
          {e_clr, e_to, e_pdf});
      chk(busy, op == IEX_CALL_OP || lpw);
      chk({stack_push.push, pc_load}, {2{op == IEX_CALL_OP}});
      if (op == IEX_CALL_OP)
         chk({stack_push, pc_load, pc_target}, {1'b1, p + 13'h1, 1'b1, ~p});
      if (op == IEX_CALL_OP || lpw)
      begin
         // dummy cycle: this issue must be dropped
         instr.op = IEX_SUM_IMM_OP;
         @(posedge mclk);
         #1;
         chk({busy, mem_wr.we, stack_push.push, working_register}, {3'b000, e_acc});
      end
   endtask : run
   // one halt or timeout pulse, then an idle cycle
   task automatic pulse(input logic h, input logic d);
      issue = 1'b0;
      halt = h;
      dog_timeout = d;
      @(posedge mclk);
      #1;
      e_to = d | (e_to & ~h);
      e_pdf = e_pdf | h;
      chk({watchdog_counter_clr, watchdog_expired_flag, powerdown_flag},
          {h, e_to, e_pdf});
      halt = 1'b0;
      dog_timeout = 1'b0;
      @(posedge mclk);
      #1;
   endtask : pulse
   // verdict and end of run
   task automatic summarize();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize
   // ****************
   // main sequence
   // ****************
   initial
   begin
      {mclk, rst, issue, halt, dog_timeout, pc_in, instr} = '0;
      {e_acc, e_mem, e_flg, e_to, e_pdf, error_cnt, samples_checked} = '0;
      rst = 1'b1;
      e_kick = IEX_NOP;
      void'($urandom(32'h243a));
      repeat (4) @(posedge mclk);
      #1;
      rst = 1'b0;
      // corners: 80+80 gives carry, overflow and zero at once
      run(IEX_SUM_IMM_OP, 8'h80, 3'h0, 1'b0);
      run(IEX_SUM_IMM_OP, 8'h80, 3'h0, 1'b0);
      run(IEX_INVERT_MEM_OP, 8'h00, 3'h0, 1'b0);
      for (i = 0; i < 8; i++)
         run(IEX_ZERO_BIT_OP, 8'h00, i[2:0], 1'b0);
      // halt beside a timeout: the expiry must not be lost
      pulse(1'b1, 1'b1);
      // flags raised before every kind of kick, repeats included
      for (i = 0; i < 6; i++)
      begin
         pulse(1'b1, 1'b0);
         pulse(1'b0, 1'b1);
         run(iex_op_type'(4'd12 + 4'(i % 3)), 8'h00, 3'h0, 1'b0);
         run(iex_op_type'(4'd13 + 4'(i / 3)), 8'h00, 3'h0, 1'b0);
      end
      for (i = 0; i < 400; i++)
         run(iex_op_type'($urandom_range(0, 15)), 8'($urandom), 3'($urandom),
             $urandom_range(0, 7) == 0);
      summarize();
   end
endmodule : test_instr_exec_add_logic_call_wdt
